// ---- design/halt_wake_pkg.sv ----
// Constants and types for the halt, idle and wake-up controller
package halt_wake_pkg;

    // ----------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] WAKE_EN_ADDR = 8'h08;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h0C;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_SLOW_IDLE_BIT = 0;
    localparam int CTRL_FAST_IDLE_BIT = 1;
    localparam int CTRL_WDT_EN_BIT = 2;
    localparam int IRQ_PIN_BIT = 0;
    localparam int IRQ_INT_BIT = 1;
    localparam int IRQ_WDT_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] CTRL_RESET = 3'h4;
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Timing: oscillator restart wait, in microseconds
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int OSC_START_US = 16;
    localparam int OSC_START_CYCLES = OSC_START_US * CLK_MHZ;

    // Power state machine
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_HALTED = 3'b001,
        ST_RESTART = 3'b010,
        ST_RESUME = 3'b011
    } power_state_type;

    // Where execution continues after waking
    localparam logic [1:0] RESUME_NEXT = 2'h0;
    localparam logic [1:0] RESUME_VECTOR = 2'h1;
    localparam logic [1:0] RESUME_WDT = 2'h2;

endpackage

// ---- design/wake_edge_capture.sv ----
// Port falling-edge capture with per-pin enables and sync
`timescale 1ns/10ps
module wake_edge_capture
    import halt_wake_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pins,
    input wire logic [WIDTH-1:0] i_enable,
    input wire logic i_arm,
    output logic o_edge
);
    // ----------------------------------------------------------------
    // Synchroniser and edge detector
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] meta_reg; // First stage, read only by sync_reg
    logic [WIDTH-1:0] sync_reg; // Second stage
    logic [WIDTH-1:0] last_reg; // Previous settled level
    logic edge_reg; // Registered result
    wire [WIDTH-1:0] falls = last_reg & ~sync_reg & i_enable;

    // Two-flop sync; pins are quiet while the core waits anyway
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '1;
            sync_reg <= '1;
            last_reg <= '1;
            edge_reg <= 1'b0;
        end else begin
            meta_reg <= i_pins;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            edge_reg <= i_arm & (|falls);
        end
    end

    assign o_edge = edge_reg;
endmodule

// ---- design/halt_wake_control.sv ----
// Halt, idle and wake-up controller with Wishbone registers
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module halt_wake_control
    import halt_wake_pkg::*;
#(
    parameter int PORT_WIDTH = 8,
    parameter int START_CYCLES = OSC_START_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // CPU side
    input wire logic i_halt_exec,
    input wire logic i_clr_wdt_exec,
    input wire logic i_int_request,
    input wire logic i_int_enabled,
    input wire logic i_stack_full,
    input wire logic i_wdt_overflow,
    input wire logic i_osc_stable,
    input wire logic [PORT_WIDTH-1:0] i_port_a,
    output logic o_cpu_hold,
    output logic o_state_freeze,
    output logic o_high_speed_clock_en,
    output logic o_low_speed_clock_en,
    output logic o_wdt_clock_en,
    output logic o_wdt_clear,
    output logic o_power_down_flag,
    output logic o_watchdog_timeout_flag,
    output logic o_resume_pulse,
    output logic [1:0] o_resume_kind,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Wait counter is sized to hold the full start-up count
    localparam int WAIT_W = $clog2(START_CYCLES + 1);
    logic [2:0] ctrl_reg; // Idle enables and watchdog enable
    logic [PORT_WIDTH-1:0] wake_en_reg; // port_a_wake_enable
    logic [IRQ_WIDTH-1:0] irq_stat_reg; // Sticky wake events
    logic [IRQ_WIDTH-1:0] irq_mask_reg; // Interrupt mask
    logic pdf_reg; // power_down_flag
    logic tof_reg; // watchdog_timeout_flag
    logic ack_reg; // Bus answer, one cycle wide
    logic [31:0] rdata_reg; // Read data, held until the next access, read or write
    power_state_type state_reg; // Power state
    power_state_type state_next; // Power state, next value
    logic [WAIT_W-1:0] wait_reg; // Restart wait count
    logic int_block_reg; // Interrupt already pending at entry
    logic [1:0] kind_reg;
    logic hold_reg;
    logic hs_reg;
    logic ls_reg;
    logic wdtck_reg;
    logic wdt_clr_reg;
    logic resume_reg;
    logic irq_reg;
    logic pin_edge; // Armed falling edge on an enabled pin

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Register select; every decoded address goes through this one compare
    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] base);
        return (adr == base);
    endfunction

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Ack low keeps a strobe that is still held from being taken twice
    wire bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
    wire wr_lo = bus_req & i_wb_we & i_wb_sel[0];
    wire hit_ctrl = addr_hit(i_wb_adr, CTRL_ADDR);
    wire hit_stat = addr_hit(i_wb_adr, STATUS_ADDR);
    wire hit_wake = addr_hit(i_wb_adr, WAKE_EN_ADDR);
    wire hit_istat = addr_hit(i_wb_adr, IRQ_STAT_ADDR);
    wire hit_imask = addr_hit(i_wb_adr, IRQ_MASK_ADDR);
    wire fast_en = ctrl_reg[CTRL_FAST_IDLE_BIT];
    wire slow_en = ctrl_reg[CTRL_SLOW_IDLE_BIT];
    wire wdt_en = ctrl_reg[CTRL_WDT_EN_BIT];

    // Halt is only honoured while running
    wire halt_take = (state_reg == ST_RUN) & i_halt_exec;
    wire halted = (state_reg == ST_HALTED);
    // Interrupt wakes only if it was not already pending at entry
    wire int_wake = halted & i_int_request & ~int_block_reg;
    wire wdt_wake = halted & i_wdt_overflow & wdt_en;
    wire pin_wake = halted & pin_edge;
    wire any_wake = int_wake | wdt_wake | pin_wake;
    wire wait_done = (wait_reg == '0) & i_osc_stable;

    // An interrupt is vectored at once only when enabled with a free stack level
    wire int_service = int_wake & i_int_enabled & ~i_stack_full;
    // Resume point: watchdog first, then serviceable interrupt, else next
    wire [1:0] kind_sel = wdt_wake ? RESUME_WDT :
        int_service ? RESUME_VECTOR :
        RESUME_NEXT;

    // Restart wait: the full count only when the fast oscillator was stopped,
    // judged by the enable applied at entry rather than by a later ctrl write
    wire [WAIT_W-1:0] wait_load = hs_reg ? '0 : START_CYCLES[WAIT_W-1:0];

    // Every wake source that fired is recorded, not only the winning one
    wire [IRQ_WIDTH-1:0] events = {wdt_wake, int_wake, pin_wake};

    // Status word: flags, whether the last wake left the plain path, power state
    wire resumed_off_path = |kind_reg;
    wire [31:0] status_word = {26'h0, state_reg, resumed_off_path, tof_reg, pdf_reg};

    wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_reg} :
        hit_stat ? status_word :
        hit_wake ? {{(32-PORT_WIDTH){1'b0}}, wake_en_reg} :
        hit_istat ? {29'h0, irq_stat_reg} :
        hit_imask ? {29'h0, irq_mask_reg} : 32'h0;

    // ----------------------------------------------------------------
    // Pin wake capture
    // ----------------------------------------------------------------
    // Edges are armed only while halted; a fall during run is not kept
    wake_edge_capture #(.WIDTH(PORT_WIDTH)) u_pins (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pins(i_port_a),
        .i_enable(wake_en_reg),
        .i_arm(halted),
        .o_edge(pin_edge)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // RUN to HALTED on the stop pulse, HALTED to RESTART on a wake event,
    // RESTART to RESUME once the wait is over and the oscillator is stable,
    // RESUME to RUN after one cycle, which raises the resume pulse
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (i_halt_exec) begin
                    state_next = ST_HALTED;
                end
            end
            ST_HALTED: begin
                if (any_wake) begin
                    state_next = ST_RESTART;
                end
            end
            ST_RESTART: begin
                if (wait_done) begin
                    state_next = ST_RESUME;
                end
            end
            ST_RESUME: state_next = ST_RUN;
            default: state_next = ST_RUN;
        endcase
    end

    // ----------------------------------------------------------------
    // Power state, restart counter and wake bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_RUN;
            wait_reg <= '0;
            int_block_reg <= 1'b0;
            kind_reg <= RESUME_NEXT;
        end else begin
            state_reg <= state_next;
            // Pending interrupt is sampled at entry only; one raised later
            // during the halt still wakes the core
            if (halt_take) begin
                int_block_reg <= i_int_request;
            end
            if (halted & any_wake) begin
                kind_reg <= kind_sel;
                // Full wait only when the fast clock was stopped
                wait_reg <= wait_load;
            end else if (wait_reg != '0) begin
                wait_reg <= wait_reg - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags: set wins over any clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pdf_reg <= 1'b0;
            tof_reg <= 1'b0;
        end else begin
            if (halt_take) begin
                pdf_reg <= 1'b1;
            end else if (i_clr_wdt_exec) begin
                pdf_reg <= 1'b0;
            end
            // Timeout set by a watchdog wake, cleared by the next halt; the two
            // never meet in one cycle, one needs HALTED and the other RUN
            if (wdt_wake) begin
                tof_reg <= 1'b1;
            end else if (halt_take) begin
                tof_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock gating and core hold outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_reg <= 1'b0;
            hs_reg <= 1'b1;
            ls_reg <= 1'b1;
            wdtck_reg <= 1'b1;
            wdt_clr_reg <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            hold_reg <= (state_next != ST_RUN);
            wdt_clr_reg <= halt_take | i_clr_wdt_exec;
            resume_reg <= (state_reg == ST_RESUME);
            wdtck_reg <= wdt_en;
            // Both clocks come back together on any wake so the core restarts
            // on the fast clock; the watchdog clock follows its enable always
            if (halt_take) begin
                hs_reg <= fast_en;
                ls_reg <= slow_en;
            end else if (halted & any_wake) begin
                hs_reg <= 1'b1;
                ls_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register writes; sticky events win over write-one-to-clear
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RESET;
            wake_en_reg <= WAKE_EN_RESET;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            // Only byte lane 0 carries writable bits; other lanes are ignored
            // Writes land at the taking edge, the same edge that raises ack
            if (wr_lo & hit_ctrl) begin
                ctrl_reg <= i_wb_dat[2:0];
            end
            if (wr_lo & hit_wake) begin
                wake_en_reg <= i_wb_dat[PORT_WIDTH-1:0];
            end
            if (wr_lo & hit_imask) begin
                irq_mask_reg <= i_wb_dat[IRQ_WIDTH-1:0];
            end
            irq_stat_reg <= (irq_stat_reg & ~((wr_lo & hit_istat) ?
                i_wb_dat[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}})) | events;
        end
    end

    // ----------------------------------------------------------------
    // Bus answer, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
            irq_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
            // Read data is latched at the taking edge of any access, read or write, and held until the next one
            rdata_reg <= bus_req ? rd_mux : rdata_reg;
            // Interrupt line lags status and mask by one cycle
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign o_wb_dat = rdata_reg;
    assign o_wb_ack = ack_reg;
    assign o_cpu_hold = hold_reg;
    assign o_state_freeze = hold_reg;
    assign o_high_speed_clock_en = hs_reg;
    assign o_low_speed_clock_en = ls_reg;
    assign o_wdt_clock_en = wdtck_reg;
    assign o_wdt_clear = wdt_clr_reg;
    assign o_power_down_flag = pdf_reg;
    assign o_watchdog_timeout_flag = tof_reg;
    assign o_resume_pulse = resume_reg;
    assign o_resume_kind = kind_reg;
    assign o_irq = irq_reg;
endmodule

// ---- tb/halt_wake_monitor.sv ----
// Port checker for the halt and wake controller
`timescale 1ns/10ps
module halt_wake_monitor
    import halt_wake_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic i_halt_exec,
    input wire logic i_clr_wdt_exec,
    input wire logic i_osc_stable,
    input wire logic o_cpu_hold,
    input wire logic o_state_freeze,
    input wire logic o_wdt_clear,
    input wire logic o_power_down_flag,
    input wire logic o_watchdog_timeout_flag,
    input wire logic o_resume_pulse,
    input wire logic [1:0] o_resume_kind
);
    // ----
    // Common clock and reset
    // ----
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Halt counts only while running; a halted core cannot issue one
    wire logic halt_taken = i_halt_exec && !o_cpu_hold;
    a_halt_flags: assert property (halt_taken |=>
        o_cpu_hold && o_power_down_flag && !o_watchdog_timeout_flag)
        else $error("halt did not set hold and flags");
    a_halt_wdt_clear: assert property (halt_taken |-> ##[1:2] o_wdt_clear)
        else $error("halt did not clear watchdog");
    a_pdf_clear_only: assert property ($fell(o_power_down_flag) |->
        $past(i_clr_wdt_exec) || $past(i_clr_wdt_exec, 2))
        else $error("power-down flag cleared without clear-watchdog");
    a_pdf_kept_wake: assert property (o_resume_pulse |-> o_power_down_flag)
        else $error("wake cleared power-down flag");
    a_freeze_hold: assert property (o_state_freeze == o_cpu_hold)
        else $error("freeze and hold disagree");
    a_osc_wait: assert property (!i_osc_stable [*4] |-> !o_resume_pulse)
        else $error("resumed before oscillator stable");
    a_resume_run: assert property (o_resume_pulse |-> !o_cpu_hold ##1 !o_resume_pulse)
        else $error("resume pulse malformed");
    a_wdt_resume: assert property (
        o_resume_pulse && o_resume_kind == RESUME_WDT |-> o_watchdog_timeout_flag)
        else $error("watchdog wake without timeout flag");
    a_wb_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus answer late");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_clr_wdt_pulse: assert property (i_clr_wdt_exec |=> o_wdt_clear)
        else $error("clear-watchdog gave no clear pulse");
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the halt and wake controller
`timescale 1ns/10ps
module tb;
    import halt_wake_pkg::*;
    // ----
    // Stimulus, observation and counters
    // ----
    logic i_clk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0;
    logic clr = 1'b0, int_req = 1'b0, int_en = 1'b1, full = 1'b0, ovf = 1'b0, osc = 1'b1;
    logic [7:0] adr = 8'h00, port = 8'hFF;
    logic [31:0] wdat = 32'h0, rdat, tmp;
    logic [3:0] sel = 4'hF;
    logic ack, hold, frz, hs, ls, wck, wclr, power_down_flag, tof, res, irq;
    logic [1:0] kind;
    int fail_count = 0, compares = 0, cycles = 0;
    // Short start-up count keeps each wake to a few cycles
    halt_wake_control #(.PORT_WIDTH(8), .START_CYCLES(4)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_halt_exec(halt), .i_clr_wdt_exec(clr), .i_int_request(int_req),
        .i_int_enabled(int_en), .i_stack_full(full), .i_wdt_overflow(ovf),
        .i_osc_stable(osc), .i_port_a(port), .o_cpu_hold(hold), .o_state_freeze(frz),
        .o_high_speed_clock_en(hs), .o_low_speed_clock_en(ls), .o_wdt_clock_en(wck),
        .o_wdt_clear(wclr), .o_power_down_flag(power_down_flag), .o_watchdog_timeout_flag(tof),
        .o_resume_pulse(res), .o_resume_kind(kind), .o_irq(irq));
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    // Hang guard: whole run is far below this
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold all until ack is seen high at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_clk); while (ack !== 1'b1);
        tmp = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(tmp, e);
    endtask
    // Halt with given control bits, then check the entry state
    task automatic halt_go(input logic [2:0] c);
        wb(1'b1, CTRL_ADDR, {29'h0, c});
        @(posedge i_clk) halt <= 1'b1;
        @(posedge i_clk) halt <= 1'b0;
        #1;
        chk({hold, power_down_flag, tof, hs, ls, wck}, {3'b110, c[1], c[0], c[2]});
    endtask
    task automatic stay_halted(input int n);
        repeat (n) @(posedge i_clk);
        #1;
        chk(hold, 1'b1);
    endtask
    task automatic wake_chk(input logic [1:0] k);
        int n = 0;
        while (res !== 1'b1 && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk({res, hold, hs, ls, kind}, {4'b1011, k});
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk({hold, frz, power_down_flag, tof, hs, ls, wck, irq}, 8'h0E);
        rd_chk(CTRL_ADDR, {29'h0, CTRL_RESET});
        rd_chk(WAKE_EN_ADDR, 32'h0);
        wb(1'b1, STATUS_ADDR, 32'hFF);
        rd_chk(STATUS_ADDR, 32'h0);
        wb(1'b1, 8'h20, 32'hFF);
        rd_chk(8'h20, 32'h0);
        $display("test reset done");
        // Every idle and sleep mode, woken by a serviced interrupt
        for (int m = 0; m < 4; m++) begin
            @(posedge i_clk) osc <= 1'b0;
            halt_go({1'b1, m[1:0]});
            @(posedge i_clk) int_req <= 1'b1;
            stay_halted(8);
            @(posedge i_clk) osc <= 1'b1;
            wake_chk(RESUME_VECTOR);
            @(posedge i_clk) int_req <= 1'b0;
        end
        $display("test modes done");
        wb(1'b1, WAKE_EN_ADDR, 32'h08);
        rd_chk(WAKE_EN_ADDR, 32'h08);
        halt_go(3'h5);
        @(posedge i_clk) port <= 8'hFB;
        stay_halted(12);
        @(posedge i_clk) port <= 8'hF3;
        wake_chk(RESUME_NEXT);
        @(posedge i_clk) port <= 8'hFF;
        $display("test pin done");
        // Disabled interrupt, then enabled but stack full
        for (int j = 0; j < 2; j++) begin
            @(posedge i_clk) {int_en, full} <= {j[0], j[0]};
            halt_go(3'h6);
            @(posedge i_clk) int_req <= 1'b1;
            wake_chk(RESUME_NEXT);
            @(posedge i_clk) int_req <= 1'b0;
        end
        $display("test deferred done");
        @(posedge i_clk) {int_en, full, int_req} <= 3'b101;
        halt_go(3'h4);
        stay_halted(8);
        @(posedge i_clk) ovf <= 1'b1;
        @(posedge i_clk) ovf <= 1'b0;
        wake_chk(RESUME_WDT);
        chk({power_down_flag, tof}, 2'b11);
        @(posedge i_clk) int_req <= 1'b0;
        @(posedge i_clk) clr <= 1'b1;
        @(posedge i_clk) clr <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        chk(power_down_flag, 1'b0);
        $display("test watchdog done");
        // Watchdog off: overflow must not wake
        halt_go(3'h0);
        @(posedge i_clk) ovf <= 1'b1;
        @(posedge i_clk) ovf <= 1'b0;
        stay_halted(10);
        @(posedge i_clk) port <= 8'hF7;
        wake_chk(RESUME_NEXT);
        @(posedge i_clk) port <= 8'hFF;
        $display("test sleep done");
        rd_chk(IRQ_STAT_ADDR, 32'h7);
        chk(irq, 1'b0);
        wb(1'b1, IRQ_MASK_ADDR, 32'h2);
        repeat (2) @(posedge i_clk);
        #1;
        chk(irq, 1'b1);
        wb(1'b1, IRQ_STAT_ADDR, 32'h2);
        rd_chk(IRQ_STAT_ADDR, 32'h5);
        chk(irq, 1'b0);
        wb(1'b1, IRQ_STAT_ADDR, 32'h5);
        rd_chk(IRQ_STAT_ADDR, 32'h0);
        $display("test irq done");
        end_of_test();
    end
endmodule
bind halt_wake_control halt_wake_monitor i_mon (.*);
